// ===== src/multi_chip_sync_config.sv
`timescale 1ns/1ps
module multi_chip_sync_config (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic wr_en_i,
  input wire logic rd_en_i,
  input wire logic [3:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic ref_clock_i,
  input wire logic data_clock_reset_input_i,
  output logic [15:0] rdata_o,
  output logic rd_valid_o,
  output logic [9:0] ref_clock_delay_o,
  output logic [1:0] latch_phase_select_o,
  output logic slave_enable_o,
  output logic reference_clock_out_a_o,
  output logic reference_clock_out_b_o,
  output logic align_pulse_o,
  output logic divider_reset_o
);

  typedef struct packed {
    logic [9:0] dly;
    logic [1:0] phase;
    logic slave;
    logic out_dis;
    logic rst_dis;
    logic [2:0] ref_sync;
    logic ref_lvl;
    logic [2:0] drst_sync;
    logic drst_lvl;
    logic [15:0] rdata;
    logic rvalid;
    logic [9:0] dly_eff;
    logic [1:0] phase_out;
    logic slave_out;
    logic out_a;
    logic out_b;
    logic align;
    logic div_rst;
  } cfg_state_t;

  localparam logic [15:0] RST = sync_cfg_pkg::SYNC_CONTROL_RESET;

  cfg_state_t st_ff;
  cfg_state_t nxt_st;
  logic load_en;
  logic clr_en;
  logic [1:0] div_phase;
  logic quarter_clk;
  logic wr_sync;

  quarter_clock_divider u_div (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .clear_i(clr_en),
    .load_i(load_en),
    .load_val_i(st_ff.phase),
    .phase_o(div_phase),
    .quarter_clk_o(quarter_clk)
  );

  always_comb begin
    nxt_st = st_ff;
    load_en = 1'b0;
    clr_en = 1'b0;
    wr_sync = wr_en_i && (addr_i == sync_cfg_pkg::SYNC_CONTROL_ADDR);
    if (wr_sync) begin
      nxt_st.dly = wdata_i[sync_cfg_pkg::DLY_MSB:sync_cfg_pkg::DLY_LSB];
      nxt_st.phase = wdata_i[sync_cfg_pkg::PH_MSB:sync_cfg_pkg::PH_LSB];
      nxt_st.slave = wdata_i[sync_cfg_pkg::SLAVE_BIT];
      nxt_st.out_dis = wdata_i[sync_cfg_pkg::OUT_DIS_BIT];
      nxt_st.rst_dis = wdata_i[sync_cfg_pkg::RST_DIS_BIT];
    end
    // Pin inputs pass three flops; a level is taken once stages two and three agree
    nxt_st.ref_sync = {st_ff.ref_sync[1:0], ref_clock_i};
    if (st_ff.ref_sync[1] == st_ff.ref_sync[2]) begin
      nxt_st.ref_lvl = st_ff.ref_sync[2];
    end
    nxt_st.drst_sync = {st_ff.drst_sync[1:0], data_clock_reset_input_i};
    if (st_ff.drst_sync[1] == st_ff.drst_sync[2]) begin
      nxt_st.drst_lvl = st_ff.drst_sync[2];
    end
    // Slave aligns its divider to the reference edge at the chosen phase
    if (st_ff.slave && nxt_st.ref_lvl && !st_ff.ref_lvl) begin
      load_en = 1'b1;
    end
    // Data clock reset acts only when enabled, and wins over alignment
    if (!st_ff.rst_dis && nxt_st.drst_lvl && !st_ff.drst_lvl) begin
      clr_en = 1'b1;
    end
    nxt_st.align = load_en && !clr_en;
    nxt_st.div_rst = clr_en;
    // Delay code saturates at the longest delay
    if (st_ff.dly >= sync_cfg_pkg::DLY_MAX_CODE) begin
      nxt_st.dly_eff = sync_cfg_pkg::DLY_MAX_CODE;
    end else begin
      nxt_st.dly_eff = st_ff.dly;
    end
    nxt_st.phase_out = st_ff.phase;
    nxt_st.slave_out = st_ff.slave;
    nxt_st.out_a = !st_ff.out_dis && quarter_clk;
    nxt_st.out_b = !st_ff.out_dis && quarter_clk;
    // Read port
    nxt_st.rvalid = rd_en_i;
    nxt_st.rdata = sync_cfg_pkg::UNMAPPED_VALUE;
    if (rd_en_i && addr_i == sync_cfg_pkg::SYNC_CONTROL_ADDR) begin
      nxt_st.rdata[sync_cfg_pkg::DLY_MSB:sync_cfg_pkg::DLY_LSB] = st_ff.dly;
      nxt_st.rdata[sync_cfg_pkg::RES_BIT] = 1'b0;
      nxt_st.rdata[sync_cfg_pkg::PH_MSB:sync_cfg_pkg::PH_LSB] = st_ff.phase;
      nxt_st.rdata[sync_cfg_pkg::SLAVE_BIT] = st_ff.slave;
      nxt_st.rdata[sync_cfg_pkg::OUT_DIS_BIT] = st_ff.out_dis;
      nxt_st.rdata[sync_cfg_pkg::RST_DIS_BIT] = st_ff.rst_dis;
    end else if (rd_en_i && addr_i == sync_cfg_pkg::RESERVED_TAIL_ADDR) begin
      nxt_st.rdata = sync_cfg_pkg::RESERVED_TAIL_VALUE;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_ff <= '0;
      st_ff.dly <= RST[sync_cfg_pkg::DLY_MSB:sync_cfg_pkg::DLY_LSB];
      st_ff.phase <= RST[sync_cfg_pkg::PH_MSB:sync_cfg_pkg::PH_LSB];
      st_ff.slave <= RST[sync_cfg_pkg::SLAVE_BIT];
      st_ff.out_dis <= RST[sync_cfg_pkg::OUT_DIS_BIT];
      st_ff.rst_dis <= RST[sync_cfg_pkg::RST_DIS_BIT];
      st_ff.phase_out <= RST[sync_cfg_pkg::PH_MSB:sync_cfg_pkg::PH_LSB];
      st_ff.slave_out <= RST[sync_cfg_pkg::SLAVE_BIT];
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rdata_o = st_ff.rdata;
  assign rd_valid_o = st_ff.rvalid;
  assign ref_clock_delay_o = st_ff.dly_eff;
  assign latch_phase_select_o = st_ff.phase_out;
  assign slave_enable_o = st_ff.slave_out;
  assign reference_clock_out_a_o = st_ff.out_a;
  assign reference_clock_out_b_o = st_ff.out_b;
  assign align_pulse_o = st_ff.align;
  assign divider_reset_o = st_ff.div_rst;

  // Checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_delay_saturates: assert property (
    ##1 ref_clock_delay_o == (($past(st_ff.dly) >= sync_cfg_pkg::DLY_MAX_CODE) ?
      sync_cfg_pkg::DLY_MAX_CODE : $past(st_ff.dly)))
    else $error("Delay code not saturated correctly");

  a_slave_phase_load: assert property (
    (load_en && !clr_en) |=> (div_phase == $past(st_ff.phase)) && align_pulse_o)
    else $error("Divider not aligned to selected phase");

  a_master_no_align: assert property (
    !st_ff.slave |-> !load_en)
    else $error("Master mode aligned to reference");

  a_ref_out_off: assert property (
    st_ff.out_dis ##1 st_ff.out_dis |=> !reference_clock_out_a_o && !reference_clock_out_b_o)
    else $error("Reference outputs active while disabled");

  a_ref_out_quarter: assert property (
    !st_ff.out_dis |=> reference_clock_out_a_o == $past(quarter_clk)
      && reference_clock_out_b_o == reference_clock_out_a_o)
    else $error("Reference outputs not clock divided by four");

  a_drst_ignored: assert property (
    st_ff.rst_dis |=> !divider_reset_o)
    else $error("Data clock reset acted while disabled");

  a_tail_read: assert property (
    (rd_en_i && addr_i == sync_cfg_pkg::RESERVED_TAIL_ADDR) |=>
      rd_valid_o && rdata_o == sync_cfg_pkg::RESERVED_TAIL_VALUE)
    else $error("Reserved tail register read wrong");

  a_field_hold: assert property (
    !(wr_en_i && addr_i == sync_cfg_pkg::SYNC_CONTROL_ADDR) |=>
      $stable({st_ff.dly, st_ff.phase, st_ff.slave, st_ff.out_dis, st_ff.rst_dis}))
    else $error("Configuration changed without a write");

  a_reserved_zero: assert property (
    (rd_en_i && addr_i == sync_cfg_pkg::SYNC_CONTROL_ADDR) |=> !rdata_o[sync_cfg_pkg::RES_BIT])
    else $error("Reserved bit read as one");

  c_slave_align: cover property (align_pulse_o);
  c_data_reset: cover property (divider_reset_o);
  c_outputs_on: cover property (!st_ff.out_dis ##1 reference_clock_out_a_o);
  c_delay_sat: cover property (ref_clock_delay_o == sync_cfg_pkg::DLY_MAX_CODE);

endmodule : multi_chip_sync_config

// ===== src/sync_cfg_pkg.sv
package sync_cfg_pkg;

  // Register port geometry
  localparam int ADDR_W = 4;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [3:0] SYNC_CONTROL_ADDR = 4'hE;
  localparam logic [3:0] RESERVED_TAIL_ADDR = 4'hF;

  // Field layout of sync_control
  localparam int DLY_MSB = 15;
  localparam int DLY_LSB = 6;
  localparam int RES_BIT = 5;
  localparam int PH_MSB = 4;
  localparam int PH_LSB = 3;
  localparam int SLAVE_BIT = 2;
  localparam int OUT_DIS_BIT = 1;
  localparam int RST_DIS_BIT = 0;
  localparam int DLY_W = 10;
  localparam int PH_W = 2;

  // Reset and fixed values
  localparam logic [15:0] SYNC_CONTROL_RESET = 16'h0003;
  localparam logic [15:0] RESERVED_TAIL_VALUE = 16'h000C;
  localparam logic [15:0] UNMAPPED_VALUE = 16'h0000;

  // Delay line: code 639 gives the longest delay
  localparam int DLY_MAX_PS = 1000;
  localparam logic [9:0] DLY_MAX_CODE = 10'h27F;

  // Divide-by-four phase counter
  localparam logic [1:0] DIV_START = 2'h0;
  localparam logic [1:0] DIV_STEP = 2'h1;
  localparam int DIV_OUT_BIT = 1;

endpackage : sync_cfg_pkg

// ===== src/quarter_clock_divider.sv
`timescale 1ns/1ps
module quarter_clock_divider (
  input wire logic mclk_i,
  input wire logic sys_rst_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [1:0] load_val_i,
  output logic [1:0] phase_o,
  output logic quarter_clk_o
);

  typedef struct packed {
    logic [1:0] phase;
  } div_state_t;

  div_state_t st_ff;
  div_state_t nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (clear_i) begin
      nxt_st.phase = sync_cfg_pkg::DIV_START;
    end else if (load_i) begin
      nxt_st.phase = load_val_i;
    end else begin
      nxt_st.phase = st_ff.phase + sync_cfg_pkg::DIV_STEP;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_ff <= '{phase: sync_cfg_pkg::DIV_START};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign phase_o = st_ff.phase;
  assign quarter_clk_o = st_ff.phase[sync_cfg_pkg::DIV_OUT_BIT];

endmodule : quarter_clock_divider

// ===== test/ref_master.sv
`timescale 1ns/1ps
module ref_master (
  input wire logic mclk_i,
  input wire logic edge_i,
  input wire logic rst_edge_i,
  output logic ref_clock_o,
  output logic data_clock_reset_o
);
  logic [3:0] ref_cnt_ff = 4'h0;
  logic [3:0] rst_cnt_ff = 4'h0;
  // One request gives one high phase of 6 cycles, longer than the input filter
  always_ff @(posedge mclk_i) begin
    ref_cnt_ff <= edge_i ? 4'h6 : (ref_cnt_ff != 4'h0 ? ref_cnt_ff - 4'h1 : 4'h0);
    rst_cnt_ff <= rst_edge_i ? 4'h6 : (rst_cnt_ff != 4'h0 ? rst_cnt_ff - 4'h1 : 4'h0);
  end
  assign ref_clock_o = (ref_cnt_ff != 4'h0);
  assign data_clock_reset_o = (rst_cnt_ff != 4'h0);
endmodule : ref_master

// ===== test/tb.sv
`timescale 1ns/1ps
module tb;
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, wr_en_i = 1'b0, rd_en_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [15:0] wdata_i = 16'h0000, rdata_o;
  logic go = 1'b0, rst_go = 1'b0, ref_clk, drst_pin, rd_valid_o, sl, oa, ob, al, clr_seen;
  logic [9:0] dly;
  logic [1:0] ph;
  int err_total = 0, samples_checked = 0, a, d;
  always #25 mclk_i = ~mclk_i;
  ref_master PEER (.mclk_i(mclk_i), .edge_i(go), .rst_edge_i(rst_go),
    .ref_clock_o(ref_clk), .data_clock_reset_o(drst_pin));
  multi_chip_sync_config DUT (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .addr_i(addr_i), .wdata_i(wdata_i), .ref_clock_i(ref_clk),
    .data_clock_reset_input_i(drst_pin), .rdata_o(rdata_o), .rd_valid_o(rd_valid_o),
    .ref_clock_delay_o(dly), .latch_phase_select_o(ph), .slave_enable_o(sl),
    .reference_clock_out_a_o(oa), .reference_clock_out_b_o(ob), .align_pulse_o(al),
    .divider_reset_o(clr_seen));
  task chk(input logic [15:0] s, input logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task give_verdict();
    if (err_total == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict
  task wr(input logic [3:0] ad, input logic [15:0] v);
    addr_i = ad; wdata_i = v; wr_en_i = 1'b1;
    @(negedge mclk_i) wr_en_i = 1'b0;
    @(negedge mclk_i);
  endtask : wr
  task rd(input logic [3:0] ad, input logic [15:0] e);
    int n;
    n = 0;
    addr_i = ad; rd_en_i = 1'b1;
    @(negedge mclk_i) rd_en_i = 1'b0;
    while (rd_valid_o !== 1'b1 && n < 3) begin
      @(negedge mclk_i);
      n++;
    end
    chk({15'h0000, rd_valid_o}, 16'h0001);
    chk(16'(n), 16'h0000);
    chk(rdata_o, e);
  endtask : rd
  // Counts high cycles of output a and cycles where a and b differ
  task outs(output int hi, output int df);
    hi = 0; df = 0;
    repeat (8) begin
      @(negedge mclk_i);
      hi += (oa === 1'b1);
      df += (oa !== ob);
    end
  endtask : outs
  // Sends one peer event and counts the resulting pulses
  task ev(input logic r);
    a = 0; d = 0;
    if (r) rst_go = 1'b1; else go = 1'b1;
    @(negedge mclk_i) begin go = 1'b0; rst_go = 1'b0; end
    repeat (14) begin
      @(negedge mclk_i);
      a += (al === 1'b1);
      d += (clr_seen === 1'b1);
    end
  endtask : ev
  task t_reset();
    rd(4'hE, 16'h0003);
    rd(4'hF, 16'h000C);
    outs(a, d);
    chk(16'(a), 16'h0000);
  endtask : t_reset
  task t_fields();
    wr(4'hE, 16'hFFDF);
    rd(4'hE, 16'hFFDF);
    chk({6'h00, dly}, 16'h027F);
    chk({15'h0000, sl}, 16'h0001);
    wr(4'hE, {10'h27E, 6'h03});
    chk({6'h00, dly}, 16'h027E);
    wr(4'hE, {10'h280, 6'h03});
    chk({6'h00, dly}, 16'h027F);
    for (int i = 0; i < 4; i++) begin
      wr(4'hE, {10'h000, 1'b0, 2'(i), 3'h3});
      chk({14'h0000, ph}, 16'(i));
    end
  endtask : t_fields
  task t_readonly();
    wr(4'h3, 16'hFFFF);
    rd(4'hF, 16'h000C);
    rd(4'h3, 16'h0000);
  endtask : t_readonly
  task t_refout();
    wr(4'hE, 16'h0001);
    outs(a, d);
    chk(16'(a), 16'h0004);
    chk(16'(d), 16'h0000);
    wr(4'hE, 16'h0003);
    outs(a, d);
    chk(16'(a), 16'h0000);
  endtask : t_refout
  task t_sync();
    wr(4'hE, 16'h0007);
    ev(1'b0);
    chk(16'(a), 16'h0001);
    wr(4'hE, 16'h0003);
    ev(1'b0);
    chk(16'(a), 16'h0000);
    ev(1'b1);
    chk(16'(d), 16'h0000);
    wr(4'hE, 16'h0002);
    ev(1'b1);
    chk(16'(d), 16'h0001);
  endtask : t_sync
  // Slave alignment loads the phase code; output a then shows bit 1 of the running phase
  task t_phase();
    int n;
    for (int i = 0; i < 4; i++) begin
      repeat (6) @(negedge mclk_i);
      wr(4'hE, {10'h000, 1'b0, 2'(i), 3'h5});
      go = 1'b1;
      @(negedge mclk_i) go = 1'b0;
      n = 0;
      while (al !== 1'b1 && n < 10) begin
        @(negedge mclk_i);
        n++;
      end
      @(negedge mclk_i);
      chk({15'h0000, oa}, 16'((i >> 1) & 1));
      @(negedge mclk_i);
      chk({15'h0000, oa}, 16'(((i + 1) >> 1) & 1));
    end
  endtask : t_phase
  // Watchdog: the whole sequence needs well under 1000 cycles
  initial begin
    #200000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (3) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    t_reset();
    t_fields();
    t_readonly();
    t_refout();
    t_sync();
    t_phase();
    give_verdict();
  end
endmodule : tb
